// ### rtl/watchdog_defines.vh
// constants for the timeout monitor: timing counts and control field reset values
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// system clock period and the nominal monitor oscillator rate
`define CLK_PERIOD_NS 100
`define OSC_RATE_HZ 128000

// shortest time-out in oscillator cycles; each code step doubles it
`define BASE_TIMEOUT_CYCLES 32'h0000_0800
// highest documented prescale code; larger codes act as this one
`define MAX_PRESCALE_CODE 4'h9
// time-outs span 16 ms at code 0 up to 8 s at the top code
`define MIN_TIMEOUT_MS 16
`define MAX_TIMEOUT_MS 8000

// change window length in system clock cycles
`define CHANGE_WINDOW_CYCLES 3'h4

// start-up delay after a time-out reset, in its own unit and in cycles
`define STARTUP_DELAY_NS 64000
`define STARTUP_DELAY_CYCLES ((`STARTUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// reset values of the control fields
`define RST_PRESCALE 4'h0
`define RST_RESET_ENABLE 1'b0
`define RST_IRQ_ENABLE 1'b0

`endif

// ### rtl/timeout_counter.v
// oscillator cycle counter with selectable doubling time-out
`include "watchdog_defines.vh"

module timeout_counter #(
   parameter CNT_W = 20
) (
   input wire clk_in,
   input wire srst_in,
   input wire ce_in,
   input wire tick_in,
   input wire restart_in,
   input wire run_in,
   input wire [3:0] prescale_in,
   output reg expire_out
);

   reg [CNT_W-1:0] count;
   wire [3:0] code;
   wire [CNT_W-1:0] terminal;
   wire [31:0] terminal_full;

   // reserved codes fall back to the longest period
   assign code = (prescale_in > `MAX_PRESCALE_CODE) ?
      `MAX_PRESCALE_CODE : prescale_in;
   // terminal count is base << code, minus one
   // worked out at full width, then cut to the counter width on purpose
   assign terminal_full = (`BASE_TIMEOUT_CYCLES << code) - 32'h0000_0001;
   assign terminal = terminal_full[CNT_W-1:0];

   // count ticks; restart always wins over an expiry in the same cycle
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         count <= {CNT_W{1'b0}};
         expire_out <= 1'b0;
      end
      else if (ce_in)
      begin
         expire_out <= 1'b0;
         if (restart_in || !run_in)
            count <= {CNT_W{1'b0}};
         else if (tick_in)
         begin
            if (count >= terminal)
            begin
               count <= {CNT_W{1'b0}};
               expire_out <= 1'b1;
            end
            else
               count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // timeout_counter

// ### rtl/watchdog_timer_with_reset.v
// timeout monitor with interrupt, reset and combined modes
`include "watchdog_defines.vh"

module watchdog_timer_with_reset #(
   parameter CNT_W = 20,
   parameter STARTUP_CYCLES = `STARTUP_DELAY_CYCLES
) (
   input wire clk_in,
   input wire srst_in,
   input wire ce_in,
   input wire osc_in,
   input wire always_on_fuse_in,
   input wire restart_in,
   input wire ctrl_wr_in,
   input wire wr_irq_flag_in,
   input wire wr_irq_enable_in,
   input wire wr_change_enable_in,
   input wire wr_reset_enable_in,
   input wire [3:0] wr_prescale_in,
   input wire flag_wr_in,
   input wire wr_reset_flag_in,
   input wire irq_vector_ack_in,
   output wire irq_out,
   output reg reset_pulse_out,
   output wire startup_hold_out,
   output wire timeout_irq_flag_out,
   output wire timeout_irq_enable_out,
   output wire change_enable_bit_out,
   output wire reset_enable_bit_out,
   output wire [3:0] prescale_select_out,
   output wire timeout_reset_flag_out
);

   reg osc_meta;
   reg osc_sync;
   reg osc_last;
   reg timeout_irq_flag;
   reg timeout_irq_enable;
   reg reset_enable_bit;
   reg timeout_reset_flag;
   reg [3:0] prescale_select;
   reg [2:0] window_cnt;
   reg [31:0] startup_cnt;
   reg fuse;
   wire osc_tick;
   wire expire;
   wire window_open;
   wire open_write;
   wire change_write;
   wire re_eff;
   wire ie_eff;
   wire run;
   wire fire_reset;
   wire fire_irq;

   // oscillator synchroniser
   // two flops before any logic; the edge detector reads the second and its delayed copy
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_last <= 1'b0;
         fuse <= 1'b0;
      end
      else if (ce_in)
      begin
         osc_meta <= osc_in;
         osc_sync <= osc_meta;
         osc_last <= osc_sync;
         fuse <= always_on_fuse_in;
      end
   end

   assign osc_tick = osc_sync & ~osc_last;

   assign re_eff = reset_enable_bit | timeout_reset_flag | fuse;
   assign ie_eff = timeout_irq_enable & ~fuse;
   assign run = re_eff | ie_eff;

   assign open_write = ctrl_wr_in & wr_change_enable_in & wr_reset_enable_in;
   assign window_open = (window_cnt != 3'h0);
   assign change_write = ctrl_wr_in & ~wr_change_enable_in & window_open;

   timeout_counter #(
      .CNT_W(CNT_W)
   ) u_counter (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .tick_in(osc_tick),
      .restart_in(restart_in | reset_pulse_out),
      .run_in(run),
      .prescale_in(prescale_select),
      .expire_out(expire)
   );

   assign fire_reset = expire & re_eff & (~ie_eff | timeout_irq_flag);
   assign fire_irq = expire & ie_eff & ~fire_reset;

   always @(posedge clk_in)
   begin
      if (srst_in)
         reset_pulse_out <= 1'b0;
      else if (ce_in)
         reset_pulse_out <= fire_reset;
   end

   // delay starts on pulse fall
   // loads while the pulse is high, so counting begins as it drops
   always @(posedge clk_in)
   begin
      if (srst_in)
         startup_cnt <= 32'h0000_0000;
      else if (ce_in)
      begin
         if (reset_pulse_out)
            startup_cnt <= STARTUP_CYCLES;
         else if (startup_cnt != 32'h0000_0000)
            startup_cnt <= startup_cnt - 32'h0000_0001;
      end
   end

   assign startup_hold_out = reset_pulse_out |
      (startup_cnt != 32'h0000_0000);

   always @(posedge clk_in)
   begin
      if (srst_in)
         window_cnt <= 3'h0;
      else if (ce_in)
      begin
         if (open_write)
            window_cnt <= `CHANGE_WINDOW_CYCLES;
         else if (change_write)
            window_cnt <= 3'h0;
         else if (window_open)
            window_cnt <= window_cnt - 3'h1;
      end
   end

   // prescale and reset-enable updates
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         prescale_select <= `RST_PRESCALE;
         reset_enable_bit <= `RST_RESET_ENABLE;
      end
      else if (ce_in)
      begin
         if (open_write)
            reset_enable_bit <= 1'b1;
         else if (change_write)
         begin
            prescale_select <= wr_prescale_in;
            reset_enable_bit <= wr_reset_enable_in;
         end
         else if (ctrl_wr_in && wr_reset_enable_in)
            reset_enable_bit <= 1'b1;
      end
   end

   // irq enable and flag; a new expiry beats any clear
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         timeout_irq_enable <= `RST_IRQ_ENABLE;
         timeout_irq_flag <= 1'b0;
      end
      else if (ce_in)
      begin
         if (reset_pulse_out)
         begin
            timeout_irq_enable <= 1'b0;
            timeout_irq_flag <= 1'b0;
         end
         else
         begin
            if (irq_vector_ack_in && re_eff)
               timeout_irq_enable <= 1'b0;
            else if (ctrl_wr_in)
               timeout_irq_enable <= wr_irq_enable_in;
            if (fire_irq)
               timeout_irq_flag <= 1'b1;
            else if (irq_vector_ack_in || (ctrl_wr_in && wr_irq_flag_in))
               timeout_irq_flag <= 1'b0;
         end
      end
   end

   // reset flag survives
   // only the power-on reset or a zero write clears it
   always @(posedge clk_in)
   begin
      if (srst_in)
         timeout_reset_flag <= 1'b0;
      else if (ce_in)
      begin
         if (fire_reset)
            timeout_reset_flag <= 1'b1;
         else if (flag_wr_in && !wr_reset_flag_in)
            timeout_reset_flag <= 1'b0;
      end
   end

   // read-back and interrupt request
   assign irq_out = timeout_irq_flag & ie_eff;
   assign timeout_irq_flag_out = timeout_irq_flag;
   assign timeout_irq_enable_out = ie_eff;
   assign change_enable_bit_out = window_open;
   assign reset_enable_bit_out = re_eff;
   assign prescale_select_out = prescale_select;
   assign timeout_reset_flag_out = timeout_reset_flag;

endmodule // watchdog_timer_with_reset

// ### sim/osc_source.sv
// oscillator model for the monitor count, sped up for simulation
module osc_source (
   input wire logic run_in,
   output logic osc_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // separate free source
   // parks low between runs so no stray edge gets counted
   initial
   begin
      osc_out = 1'h0;
      forever
      begin
         #500;
         osc_out = run_in && !osc_out;
      end
   end
endmodule // osc_source

// ### sim/watchdog_monitor.sv
// checker for the timeout monitor ports
module watchdog_checker (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic always_on_fuse_in,
   input wire logic ctrl_wr_in,
   input wire logic wr_change_enable_in,
   input wire logic wr_reset_enable_in,
   input wire logic reset_pulse_out,
   input wire logic startup_hold_out,
   input wire logic timeout_irq_enable_out,
   input wire logic change_enable_bit_out,
   input wire logic reset_enable_bit_out,
   input wire logic [3:0] prescale_select_out,
   input wire logic timeout_reset_flag_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   // write that opens the change window
   wire logic open_wr = ce_in && ctrl_wr_in && wr_change_enable_in
      && wr_reset_enable_in;
   a_pulse_one_cycle: assert property (
      reset_pulse_out |=> !reset_pulse_out) else $error("long pulse");
   // hold spans the pulse plus the four cycles set in the bench
   a_hold_span: assert property (
      reset_pulse_out |-> startup_hold_out[*5] ##1 !startup_hold_out)
      else $error("hold length");
   a_pulse_sets_flag: assert property (
      reset_pulse_out |-> timeout_reset_flag_out) else $error("no flag");
   a_flag_forces_enable: assert property (
      timeout_reset_flag_out |-> reset_enable_bit_out)
      else $error("enable low");
   a_pulse_needs_enable: assert property (
      reset_pulse_out |-> $past(reset_enable_bit_out))
      else $error("reset in irq mode");
   a_window_closes: assert property (
      open_wr ##1 (ce_in && !ctrl_wr_in)[*4] |=> !change_enable_bit_out)
      else $error("window open");
   a_locked_prescale: assert property (
      ce_in && ctrl_wr_in && !change_enable_bit_out
      |=> $stable(prescale_select_out)) else $error("prescale moved");
   a_fuse_locks_bits: assert property (
      (!srst_in && always_on_fuse_in)[*2]
      |-> reset_enable_bit_out && !timeout_irq_enable_out)
      else $error("fuse lock");
   c_reset: cover property (reset_pulse_out);
   c_open: cover property (open_wr);
   c_fuse: cover property (always_on_fuse_in && reset_enable_bit_out);
endmodule // watchdog_checker

bind watchdog_timer_with_reset watchdog_checker i_watchdog_checker (.*);

// ### sim/watchdog_timer_with_reset_tb.sv
// self-checking bench for the timeout monitor
module watchdog_timer_with_reset_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'h0, srst_in = 1'h1, ce_in = 1'h1, osc_in, run = 1'h0;
   logic always_on_fuse_in = 1'h0, restart_in = 1'h0, ctrl_wr_in = 1'h0;
   logic wr_irq_flag_in = 1'h0, wr_irq_enable_in = 1'h0, flag_wr_in = 1'h0;
   logic wr_change_enable_in = 1'h0, wr_reset_enable_in = 1'h0;
   logic wr_reset_flag_in = 1'h0, irq_vector_ack_in = 1'h0;
   logic [3:0] wr_prescale_in = 4'h0, prescale_select_out;
   logic irq_out, reset_pulse_out, startup_hold_out, timeout_irq_flag_out;
   logic timeout_irq_enable_out, change_enable_bit_out;
   logic reset_enable_bit_out, timeout_reset_flag_out;
   int err_count = 0, tests_run = 0, ticks = 0;
   // short start-up hold keeps the run brief
   watchdog_timer_with_reset #(.STARTUP_CYCLES(4))
      i_watchdog_timer_with_reset (.*);
   osc_source i_osc_source (.run_in(run), .osc_out(osc_in));
   // clock and oscillator edge count
   always #50 clk_in = !clk_in;
   always @(posedge osc_in) ticks++;
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s exp %0h got %0h", n, e, g);
      end
   endtask
   // one control write, taken at the second edge
   task automatic ctl(input logic ie, c, re, input logic [3:0] p);
      @(posedge clk_in);
      ctrl_wr_in <= 1'h1;
      wr_irq_enable_in <= ie;
      wr_change_enable_in <= c;
      wr_reset_enable_in <= re;
      wr_prescale_in <= p;
      @(posedge clk_in);
      ctrl_wr_in <= 1'h0;
   endtask
   // one-cycle strobe: 0 restart, 1 vector, 2 flag clear
   task automatic pulse(input int k);
      @(posedge clk_in);
      restart_in <= (k == 0);
      irq_vector_ack_in <= (k == 1);
      flag_wr_in <= (k == 2);
      @(posedge clk_in);
      {restart_in, irq_vector_ack_in, flag_wr_in} <= 3'h0;
   endtask
   // run the oscillator until the monitor reacts, bounded
   task automatic expire;
      run <= 1'h1;
      for (int n = 0; n < 30000; n++)
      begin
         @(negedge clk_in);
         if (timeout_irq_flag_out === 1'h1 || reset_pulse_out === 1'h1)
            break;
      end
      run <= 1'h0;
   endtask
   task automatic end_of_test;
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard, above the longest expected run
   initial
   begin
      repeat (95000) @(posedge clk_in);
      err_count++;
      end_of_test;
   end
   initial
   begin
      repeat (3) @(posedge clk_in);
      srst_in <= 1'h0;
      @(negedge clk_in);
      chk("idle", 32'h0000_0000, {reset_enable_bit_out, prescale_select_out});
      ctl(0, 0, 1, 4'h3);
      ctl(0, 0, 0, 4'h3);
      @(negedge clk_in);
      chk("lock", 32'h0000_0001, {prescale_select_out, reset_enable_bit_out});
      ctl(0, 1, 1, 4'h7);
      @(negedge clk_in);
      chk("open", 32'h0000_0010, {change_enable_bit_out, prescale_select_out});
      ctl(0, 0, 0, 4'h9);
      @(negedge clk_in);
      chk("new", 32'h0000_0012, {prescale_select_out, reset_enable_bit_out});
      // a write after the window has lapsed is refused
      ctl(0, 1, 1, 4'h0);
      repeat (4) @(posedge clk_in);
      ctl(0, 0, 0, 4'h2);
      @(negedge clk_in);
      chk("late", 32'h0000_0013, {prescale_select_out, reset_enable_bit_out});
      ctl(0, 1, 1, 4'h0);
      ctl(1, 0, 0, 4'h0);
      // interrupt mode, restarted half way through the count
      pulse(0);
      ticks = 0;
      run <= 1'h1;
      wait (ticks == 1000);
      repeat (5) @(posedge clk_in);
      pulse(0);
      ticks = 0;
      expire;
      chk("ticks", 32'h0000_0800, ticks);
      chk("irq", 32'h0000_0006, {irq_out, timeout_irq_flag_out, reset_pulse_out});
      pulse(1);
      @(negedge clk_in);
      chk("ack", 32'h0000_0001, {timeout_irq_flag_out, timeout_irq_enable_out});
      // reset mode: pulse, flag, enable kept
      ctl(0, 0, 1, 4'h0);
      pulse(0);
      ticks = 0;
      expire;
      chk("ticks", 32'h0000_0800, ticks);
      chk("rst", 32'h0000_0007, {reset_pulse_out, timeout_reset_flag_out, reset_enable_bit_out});
      ctl(0, 1, 1, 4'h0);
      ctl(0, 0, 0, 4'h0);
      @(negedge clk_in);
      chk("held", 32'h0000_0001, reset_enable_bit_out);
      pulse(2);
      ctl(0, 1, 1, 4'h0);
      ctl(0, 0, 0, 4'h0);
      @(negedge clk_in);
      chk("off", 32'h0000_0000, {timeout_reset_flag_out, reset_enable_bit_out});
      // combined mode: the vector drops the irq enable, leaving reset mode
      ctl(1, 0, 1, 4'h0);
      @(negedge clk_in);
      chk("both", 32'h0000_0003, {timeout_irq_enable_out, reset_enable_bit_out});
      pulse(1);
      @(negedge clk_in);
      chk("vec", 32'h0000_0001, {timeout_irq_enable_out, reset_enable_bit_out});
      // fuse forces reset mode whatever is written
      @(posedge clk_in);
      always_on_fuse_in <= 1'h1;
      ctl(1, 0, 0, 4'h0);
      @(negedge clk_in);
      chk("fuse", 32'h0000_0001, {timeout_irq_enable_out, reset_enable_bit_out});
      end_of_test;
   end
endmodule // watchdog_timer_with_reset_tb
